// ---- lcg_defines.svh ----
// Constants for the logic cell group slice: offsets, fields, reset values
//
// Summary of operation
// - Group offers ten shared controls: two clocks, two gates, clears, loads, add/subtract.
// - Each group clock is paired with its own clock gate.
// - Dual-edge use makes clock two the falling edge of clock one.
// - A low clock gate stops its clock so registers hold.
// - Preset to one is an asynchronous load with load value high.
// - Each cell has a four-input table realising any function.
// - Cell register works as D, T, JK or SR flip-flop.
// - Asynchronous load value comes from the cell's third table input.
// - Combinational use routes the table result around the register.
// - Three outputs each pick table or register independently.
// - Packing feeds the register output back into its own table.
// - Cells give table cascade and register cascade outputs for shift chains.
// - Subtract inverts the B bit of every arithmetic-mode cell and forces the low carry-in to one.
// - Add/subtract select drives carry into the first cell of the chain.
// - Normal or arithmetic mode steers eight cell inputs differently.
// - Group controls work in all modes; add/subtract inverts B only in arithmetic but forces carry-in in all.
// - Normal mode table takes third input or the carry as one input.
// - Arithmetic mode precomputes sums and carries for carry-in zero and one.
// - Group carry-in picks the chain whose level picks the sum.
// - Incoming chain carry selects outgoing carry of the same chain.
// - Arithmetic mode offers counter enable and up/down from data inputs.
// - Synchronous clear and load act on each register only at its own enabled clock edge.
// - Asynchronous clear wins over asynchronous preset/load.
// - Registers power up low unless individually set high.
`ifndef LCG_DEFINES_SVH
`define LCG_DEFINES_SVH

`define LCG_CELLS 10
`define LCG_CFG_W 29
// Per-cell configuration words sit at index * 4
`define LCG_CFG_BASE 8'h00
`define LCG_CTRL_OFS 8'h28
`define LCG_STAT_OFS 8'h2C

// Cell configuration fields
`define LCG_F_LUT_HI 15
`define LCG_F_ARITH 16
`define LCG_F_FF_LO 17
`define LCG_F_FF_HI 18
`define LCG_F_CLK_TWO 19
`define LCG_F_CLR_TWO 20
`define LCG_F_CARRY_LUT 21
`define LCG_F_PACK 22
`define LCG_F_SHIFT 23
`define LCG_F_OUT1_REG 24
`define LCG_F_OUT2_REG 25
`define LCG_F_LOCAL_REG 26
`define LCG_F_PWRUP_HI 27
`define LCG_F_COUNTER 28

// Group control fields
`define LCG_C_DUAL_EDGE 0
`define LCG_C_INIT 1

`define LCG_CFG_RST 29'h0000000
`define LCG_CTRL_RST 1'h0

`endif

// ---- lcg_pkg.sv ----
// Types shared by the logic cell group slice
package lcg_pkg;

    typedef enum logic [1:0] {
        LCG_FF_D = 2'h0,
        LCG_FF_T = 2'h1,
        LCG_FF_JK = 2'h2,
        LCG_FF_SR = 2'h3
    } lcg_ff_type;

    typedef logic [3:0] lcg_index_type;

endpackage : lcg_pkg

// ---- lcg_slice.sv ----
// Ten-cell logic group: tables, carry-select chain, cell registers, APB configuration
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "lcg_defines.svh"

module lcg_slice (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_group_clock_one,
    input wire logic i_group_clock_two,
    input wire logic i_group_clock_gate_one,
    input wire logic i_group_clock_gate_two,
    input wire logic i_async_clear_one,
    input wire logic i_async_clear_two,
    input wire logic i_async_load,
    input wire logic i_sync_clear,
    input wire logic i_sync_load,
    input wire logic i_sub_sel,
    input wire logic [9:0] i_lut_input_one,
    input wire logic [9:0] i_lut_input_two,
    input wire logic [9:0] i_lut_input_three,
    input wire logic [9:0] i_lut_input_four,
    input wire logic i_group_carry_in,
    input wire logic i_zero_chain_carry_in,
    input wire logic i_one_chain_carry_in,
    input wire logic i_reg_chain_in,
    output logic [9:0] o_route_one,
    output logic [9:0] o_route_two,
    output logic [9:0] o_local,
    output logic [9:0] o_lut_chain,
    output logic [9:0] o_reg_chain,
    output logic o_zero_chain_carry_out,
    output logic o_one_chain_carry_out
);

    // ==========================================================
    // Address decode
    // ==========================================================
    // Index 0..9 cell words, 10 control, 11 status, 15 unmapped
    function automatic lcg_pkg::lcg_index_type lcg_decode(input logic [7:0] addr);
        if (addr[1:0] != 2'h0 || addr > `LCG_STAT_OFS) begin
            lcg_decode = 4'hF;
        end else begin
            lcg_decode = addr[5:2];
        end
    endfunction : lcg_decode

    // ==========================================================
    // State
    // ==========================================================
    logic [`LCG_CFG_W-1:0] cfg_r [`LCG_CELLS];
    logic [`LCG_CFG_W-1:0] cfg_nxt [`LCG_CELLS];
    logic dual_r, dual_nxt;
    logic init_r, init_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic clk1_d_r, clk1_d_nxt;
    logic clk2_d_r, clk2_d_nxt;
    logic [9:0] q_r, q_nxt;
    logic [9:0] out1_r, out1_nxt;
    logic [9:0] out2_r, out2_nxt;
    logic [9:0] local_r, local_nxt;
    logic [9:0] chain_r, chain_nxt;
    logic zco_r, zco_nxt;
    logic oco_r, oco_nxt;

    logic fire1, fire2, ev2;
    logic sub_eff;
    logic [9:0] clear_hit, fire_cell, cnt_ok, res_v;
    logic [10:0] zc_v, oc_v;
    lcg_pkg::lcg_index_type wr_idx, rd_idx;

    // ==========================================================
    // APB slave
    // ==========================================================
    // Zero wait states; a frozen clock enable stalls the access
    assign o_pready = i_ce;
    assign o_prdata = prdata_r;
    assign o_pslverr = pslverr_r;
    assign wr_idx = lcg_decode(i_paddr);
    assign rd_idx = lcg_decode(i_paddr);

    always_comb begin
        for (int i = 0; i < `LCG_CELLS; i++) begin
            cfg_nxt[i] = cfg_r[i];
        end
        dual_nxt = dual_r;
        init_nxt = 1'b0;
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (i_psel && !i_penable) begin
            // Answer prepared in setup so read data leaves a flop
            pslverr_nxt = (rd_idx == 4'hF);
            prdata_nxt = 32'h00000000;
            if (!i_pwrite) begin
                if (rd_idx < 4'hA) begin
                    prdata_nxt[`LCG_CFG_W-1:0] = cfg_r[rd_idx];
                end else if (rd_idx == 4'hA) begin
                    prdata_nxt[`LCG_C_DUAL_EDGE] = dual_r;
                end else if (rd_idx == 4'hB) begin
                    prdata_nxt[9:0] = q_r;
                    prdata_nxt[16] = zco_r;
                    prdata_nxt[17] = oco_r;
                end
            end
        end
        if (i_psel && i_penable && i_pwrite) begin
            if (wr_idx < 4'hA) begin
                cfg_nxt[wr_idx] = i_pwdata[`LCG_CFG_W-1:0];
            end else if (wr_idx == 4'hA) begin
                dual_nxt = i_pwdata[`LCG_C_DUAL_EDGE];
                init_nxt = i_pwdata[`LCG_C_INIT];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < `LCG_CELLS; i++) begin
                cfg_r[i] <= `LCG_CFG_RST;
            end
            dual_r <= `LCG_CTRL_RST;
            init_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (i_ce) begin
            for (int i = 0; i < `LCG_CELLS; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
            dual_r <= dual_nxt;
            init_r <= init_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ==========================================================
    // Group clocks and gates
    // ==========================================================
    // Group clocks are sampled levels; an edge is a change seen between cycles
    // Ten group controls share every cell: clocks, gates, clears, loads, add/sub
    always_comb begin
        clk1_d_nxt = i_group_clock_one;
        clk2_d_nxt = i_group_clock_two;
        ev2 = dual_r ? (!i_group_clock_one && clk1_d_r)
                     : (i_group_clock_two && !clk2_d_r);
        fire1 = i_group_clock_one && !clk1_d_r && i_group_clock_gate_one;
        fire2 = ev2 && i_group_clock_gate_two;
    end

    // ==========================================================
    // Cells: tables, carry-select chain, registers
    // ==========================================================
    always_comb begin
        logic [`LCG_CFG_W-1:0] c;
        logic a, b, sel, sum, lutv, dsrc, fv, prev_q;
        logic [3:0] idx;
        c = '0;
        a = 1'b0;
        b = 1'b0;
        sel = 1'b0;
        sum = 1'b0;
        lutv = 1'b0;
        dsrc = 1'b0;
        fv = 1'b0;
        prev_q = 1'b0;
        idx = 4'h0;
        q_nxt = q_r;
        // Up/down from the first cell's fourth input when it runs as a counter
        sub_eff = i_sub_sel || (cfg_r[0][`LCG_F_COUNTER] && i_lut_input_four[0]);
        zc_v[0] = sub_eff ? 1'b1 : i_zero_chain_carry_in;
        oc_v[0] = sub_eff ? 1'b1 : i_one_chain_carry_in;
        for (int i = 0; i < `LCG_CELLS; i++) begin
            c = cfg_r[i];
            a = c[`LCG_F_PACK] ? q_r[i] : i_lut_input_one[i];
            // Inversion only reaches cells in arithmetic mode
            b = i_lut_input_two[i] ^ (sub_eff && c[`LCG_F_ARITH]);
            sel = i_group_carry_in ? oc_v[i] : zc_v[i];
            sum = sel ? !(a ^ b) : (a ^ b);
            zc_v[i+1] = zc_v[i] ? (a || b) : (a && b);
            oc_v[i+1] = oc_v[i] ? (a || b) : (a && b);
            idx = {i_lut_input_four[i],
                   c[`LCG_F_CARRY_LUT] ? sel : i_lut_input_three[i],
                   i_lut_input_two[i], a};
            lutv = c[idx];
            res_v[i] = c[`LCG_F_ARITH] ? sum : lutv;
            prev_q = (i == 0) ? i_reg_chain_in : q_r[(i == 0) ? 0 : i - 1];
            dsrc = c[`LCG_F_SHIFT] ? prev_q : res_v[i];
            case (lcg_pkg::lcg_ff_type'(c[`LCG_F_FF_HI:`LCG_F_FF_LO]))
                lcg_pkg::LCG_FF_D: fv = dsrc;
                lcg_pkg::LCG_FF_T: fv = q_r[i] ^ dsrc;
                lcg_pkg::LCG_FF_JK: fv = (dsrc && !q_r[i]) || (!i_lut_input_four[i] && q_r[i]);
                lcg_pkg::LCG_FF_SR: fv = i_lut_input_four[i] ? 1'b0 : (dsrc || q_r[i]);
                default: fv = dsrc;
            endcase
            clear_hit[i] = c[`LCG_F_CLR_TWO] ? i_async_clear_two : i_async_clear_one;
            fire_cell[i] = c[`LCG_F_CLK_TWO] ? fire2 : fire1;
            // Counter enable taken from the third data input
            cnt_ok[i] = !(c[`LCG_F_ARITH] && c[`LCG_F_COUNTER]) || i_lut_input_three[i];
            if (clear_hit[i]) begin
                q_nxt[i] = 1'b0;
            end else if (init_r) begin
                // Power-up state applied as a load of the chosen level
                q_nxt[i] = c[`LCG_F_PWRUP_HI];
            end else if (i_async_load) begin
                q_nxt[i] = i_lut_input_three[i];
            end else if (fire_cell[i] && cnt_ok[i]) begin
                if (i_sync_clear) begin
                    q_nxt[i] = 1'b0;
                end else if (i_sync_load) begin
                    q_nxt[i] = i_lut_input_three[i];
                end else begin
                    q_nxt[i] = fv;
                end
            end
        end
    end

    // ==========================================================
    // Cell outputs
    // ==========================================================
    always_comb begin
        for (int i = 0; i < `LCG_CELLS; i++) begin
            out1_nxt[i] = cfg_r[i][`LCG_F_OUT1_REG] ? q_nxt[i] : res_v[i];
            out2_nxt[i] = cfg_r[i][`LCG_F_OUT2_REG] ? q_nxt[i] : res_v[i];
            local_nxt[i] = cfg_r[i][`LCG_F_LOCAL_REG] ? q_nxt[i] : res_v[i];
        end
        chain_nxt = res_v;
        zco_nxt = zc_v[`LCG_CELLS];
        oco_nxt = oc_v[`LCG_CELLS];
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clk1_d_r <= 1'b0;
            clk2_d_r <= 1'b0;
            q_r <= 10'h000;
            out1_r <= 10'h000;
            out2_r <= 10'h000;
            local_r <= 10'h000;
            chain_r <= 10'h000;
            zco_r <= 1'b0;
            oco_r <= 1'b0;
        end else if (i_ce) begin
            clk1_d_r <= clk1_d_nxt;
            clk2_d_r <= clk2_d_nxt;
            q_r <= q_nxt;
            out1_r <= out1_nxt;
            out2_r <= out2_nxt;
            local_r <= local_nxt;
            chain_r <= chain_nxt;
            zco_r <= zco_nxt;
            oco_r <= oco_nxt;
        end
    end

    assign o_route_one = out1_r;
    assign o_route_two = out2_r;
    assign o_local = local_r;
    assign o_lut_chain = chain_r;
    assign o_reg_chain = q_r;
    assign o_zero_chain_carry_out = zco_r;
    assign o_one_chain_carry_out = oco_r;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    logic quiet0;
    assign quiet0 = !clear_hit[0] && !init_r && !i_async_load;

    sequence s_clear0;
        i_ce && clear_hit[0];
    endsequence

    sequence s_fire0;
        i_ce && quiet0 && fire_cell[0] && cnt_ok[0];
    endsequence

    clear_wins_a: assert property (s_clear0 and i_async_load |=> !q_r[0])
        else $error("Async clear lost to async load");

    gate_hold_a: assert property (i_ce && quiet0 && !fire_cell[0] |=> $stable(q_r[0]))
        else $error("Register changed without an enabled edge");

    aload_val_a: assert property (i_ce && !clear_hit[0] && !init_r && i_async_load
        |=> q_r[0] == $past(i_lut_input_three[0]))
        else $error("Async load did not take the third input");

    sub_carry_a: assert property (i_sub_sel |-> zc_v[0] && oc_v[0])
        else $error("Subtract did not force carry-in high");

    sclr_first_a: assert property (s_fire0 ##0 i_sync_clear && i_sync_load |=> !q_r[0])
        else $error("Sync clear did not beat sync load");

    sload_val_a: assert property (s_fire0 ##0 !i_sync_clear && i_sync_load
        |=> q_r[0] == $past(i_lut_input_three[0]))
        else $error("Sync load value wrong");

    init_level_a: assert property (i_ce && init_r && !clear_hit[0]
        |=> q_r[0] == $past(cfg_r[0][`LCG_F_PWRUP_HI]))
        else $error("Power-up level not applied");

    dual_edge_a: assert property (dual_r && i_group_clock_gate_two && $fell(i_group_clock_one)
        && i_ce |-> fire2)
        else $error("Falling edge of clock one missed on clock two");

    route_lag_a: assert property (i_ce ##1 i_ce |-> o_lut_chain == $past(res_v))
        else $error("Table cascade output out of step");

endmodule : lcg_slice

// ---- lcg_nbr_model.sv ----
// Neighbour cells and routing model: group clocks, chain carries, shift input
`timescale 1ns/1ps

module lcg_nbr_model (
    input wire logic i_sys_clk,
    input wire logic i_fire,
    input wire logic i_shift_bit,
    output logic o_group_clock_one,
    output logic o_group_clock_two,
    output logic o_zero_chain_carry_in,
    output logic o_one_chain_carry_in,
    output logic o_reg_chain_in
);
    logic [2:0] cnt_r = 3'h0;
    logic [2:0] cnt_nxt;
    // ==========
    // Clock pulse
    // Low, high, low: the slice needs a low sample before the high one
    always_comb begin
        cnt_nxt = (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
        if (i_fire) begin
            cnt_nxt = 3'h4;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        cnt_r <= cnt_nxt;
    end
    // Clock stands still between pulses
    assign o_group_clock_one = (cnt_r == 3'h3) || (cnt_r == 3'h2);
    assign o_group_clock_two = o_group_clock_one;
    // Lower-order cell: zero chain carries 0, one chain carries 1
    assign o_zero_chain_carry_in = 1'h0;
    assign o_one_chain_carry_in = 1'h1;
    assign o_reg_chain_in = i_shift_bit;
endmodule : lcg_nbr_model

// ---- logic_cell_group_slice_test.sv ----
// Self-checking bench for the ten-cell logic group slice
`timescale 1ns/1ps
`include "lcg_defines.svh"

module logic_cell_group_slice_test;
    typedef struct packed {
        logic [9:0] a;
        logic [9:0] b;
        logic s;
        logic c;
        logic [10:0] e;
    } lcg_row_type;
    logic clk = 1'h0, nrst = 1'h0, ce = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    logic gate1 = 1'h1, gate2 = 1'h1, aclr1 = 1'h0, aclr2 = 1'h0, aload = 1'h0;
    logic sclr = 1'h0, sload = 1'h0, sub = 1'h0, gci = 1'h0, fire = 1'h0, shift = 1'h0;
    logic [9:0] in1 = 10'h000, in2 = 10'h000, in3 = 10'h000, in4 = 10'h000;
    logic gck1, gck2, zc, oc, rci, zco, oco;
    logic [9:0] r1, r2, loc, lch, rch;
    int fails = 0;
    int samples_checked = 0;
    lcg_row_type rows [6] = '{
        '{10'h155, 10'h0AB, 1'h0, 1'h0, 11'h200}, '{10'h3FF, 10'h001, 1'h0, 1'h0, 11'h400},
        '{10'h100, 10'h001, 1'h1, 1'h0, 11'h4FF}, '{10'h000, 10'h001, 1'h1, 1'h0, 11'h3FF},
        '{10'h001, 10'h001, 1'h0, 1'h1, 11'h003}, '{10'h3FF, 10'h000, 1'h0, 1'h1, 11'h400}};
    logic [15:0] masks [2] = '{16'h8000, 16'h6996};
    logic [9:0] lut_exp [2] = '{10'h180, 10'h269};
    localparam logic [31:0] DFF = 32'h0000AAAA | (32'h1 << `LCG_F_OUT1_REG);

    always #12.5 clk = ~clk;

    lcg_slice u_lcg_slice (.i_sys_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_group_clock_one(gck1), .i_group_clock_two(gck2),
        .i_group_clock_gate_one(gate1), .i_group_clock_gate_two(gate2),
        .i_async_clear_one(aclr1), .i_async_clear_two(aclr2), .i_async_load(aload),
        .i_sync_clear(sclr), .i_sync_load(sload), .i_sub_sel(sub),
        .i_lut_input_one(in1), .i_lut_input_two(in2), .i_lut_input_three(in3),
        .i_lut_input_four(in4), .i_group_carry_in(gci), .i_zero_chain_carry_in(zc),
        .i_one_chain_carry_in(oc), .i_reg_chain_in(rci), .o_route_one(r1),
        .o_route_two(r2), .o_local(loc), .o_lut_chain(lch), .o_reg_chain(rch),
        .o_zero_chain_carry_out(zco), .o_one_chain_carry_out(oco));

    lcg_nbr_model u_lcg_nbr_model (.i_sys_clk(clk), .i_fire(fire), .i_shift_bit(shift),
        .o_group_clock_one(gck1), .o_group_clock_two(gck2), .o_zero_chain_carry_in(zc),
        .o_one_chain_carry_in(oc), .o_reg_chain_in(rci));

    // ==========
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic cfg_all(input logic [31:0] w);
        for (int i = 0; i < 10; i++) begin
            apb(1'h1, 8'(i * 4), w);
        end
    endtask : cfg_all

    task automatic pulse;
        @(posedge clk);
        fire <= 1'h1;
        @(posedge clk);
        fire <= 1'h0;
        repeat (8) @(posedge clk);
    endtask : pulse

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // ==========
    // Watchdog
    initial begin
        #(25 * 20000);
        fails++;
        test_done();
    end

    // ==========
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        chk({22'h0, rch}, 32'h0);
        nrst <= 1'h1;
        apb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 8'h2C, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'h1, 8'h24, 32'hFFFFFFFF);
        apb(1'h0, 8'h24, 32'h0);
        chk(rd, 32'h1FFFFFFF);
        // Adder and subtractor rows, all cells arithmetic
        cfg_all(32'h1 << `LCG_F_ARITH);
        foreach (rows[k]) begin
            in1 <= rows[k].a;
            in2 <= rows[k].b;
            sub <= rows[k].s;
            gci <= rows[k].c;
            repeat (3) @(posedge clk);
            chk({21'h0, (gci ? oco : zco), r1}, {21'h0, rows[k].e});
        end
        sub <= 1'h0;
        gci <= 1'h0;
        // Normal mode tables
        in1 <= 10'h3FF;
        in2 <= 10'h3F0;
        in3 <= 10'h3CC;
        in4 <= 10'h1AA;
        foreach (masks[k]) begin
            cfg_all({16'h0, masks[k]});
            repeat (3) @(posedge clk);
            chk({22'h0, r1}, {22'h0, lut_exp[k]});
        end
        in3 <= 10'h000;
        in4 <= 10'h000;
        // Register tests, D type
        cfg_all(DFF);
        in1 <= 10'h2D5;
        pulse();
        chk({22'h0, rch}, 32'h2D5);
        in1 <= 10'h0F0;
        repeat (3) @(posedge clk);
        chk({r2, r1}, {10'h0F0, 10'h2D5});
        chk({12'h0, loc, lch}, {12'h0, 10'h0F0, 10'h0F0});
        gate1 <= 1'h0;
        pulse();
        chk({22'h0, rch}, 32'h2D5);
        gate1 <= 1'h1;
        sclr <= 1'h1;
        sload <= 1'h1;
        pulse();
        chk({22'h0, rch}, 32'h0);
        sclr <= 1'h0;
        sload <= 1'h0;
        in3 <= 10'h3FF;
        aload <= 1'h1;
        repeat (3) @(posedge clk);
        chk({22'h0, rch}, 32'h3FF);
        aclr2 <= 1'h1;
        repeat (3) @(posedge clk);
        chk({22'h0, rch}, 32'h3FF);
        aclr2 <= 1'h0;
        aclr1 <= 1'h1;
        repeat (3) @(posedge clk);
        chk({22'h0, rch}, 32'h0);
        aclr1 <= 1'h0;
        aload <= 1'h0;
        // Toggle type
        cfg_all(32'h0000AAAA | (32'h1 << `LCG_F_FF_LO));
        in1 <= 10'h3FF;
        pulse();
        chk({22'h0, rch}, 32'h3FF);
        pulse();
        chk({22'h0, rch}, 32'h0);
        // JK type: J from the table, K from input four
        cfg_all(32'h0000AAAA | (32'h1 << `LCG_F_FF_HI));
        pulse();
        chk({22'h0, rch}, 32'h3FF);
        in1 <= 10'h000;
        in4 <= 10'h3FF;
        pulse();
        chk({22'h0, rch}, 32'h0);
        in4 <= 10'h000;
        // Shift chain beside unrelated tables
        cfg_all(DFF | (32'h1 << `LCG_F_SHIFT));
        shift <= 1'h1;
        pulse();
        chk({22'h0, rch}, 32'h001);
        pulse();
        chk({22'h0, rch}, 32'h003);
        // Dual edge on clock two with its own gate
        cfg_all(DFF | (32'h1 << `LCG_F_CLK_TWO));
        apb(1'h1, 8'h28, 32'h1);
        in1 <= 10'h155;
        gate2 <= 1'h0;
        pulse();
        chk({22'h0, rch}, 32'h003);
        gate2 <= 1'h1;
        pulse();
        chk({22'h0, rch}, 32'h155);
        // Power-up high option through the init pulse
        cfg_all(DFF | (32'h1 << `LCG_F_PWRUP_HI));
        apb(1'h1, 8'h28, 32'h2);
        repeat (3) @(posedge clk);
        chk({22'h0, rch}, 32'h3FF);
        apb(1'h0, 8'h2C, 32'h0);
        chk(rd & 32'h3FF, 32'h3FF);
        test_done();
    end
endmodule : logic_cell_group_slice_test
